// ### rtl/vah_pkg.sv
// Package: constants, types and register map of the voltage angle hold block
package vah_pkg;
  // Clock and program cycle timing
  localparam int CLK_NS = 10;
  localparam int PC_NS = 1000000;
  localparam int PC_CLKS = (PC_NS + CLK_NS - 1) / CLK_NS;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_THR = 8'h04;
  localparam logic [7:0] OFF_IMIN = 8'h08;
  localparam logic [7:0] OFF_MAXT = 8'h0c;
  localparam logic [7:0] OFF_HSEL = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_ISR = 8'h18;
  localparam logic [7:0] OFF_IMR = 8'h1c;
  localparam logic [7:0] OFF_HOUT = 8'h20;
  localparam logic [7:0] OFF_THDA = 8'h24;
  localparam logic [7:0] OFF_THDP = 8'h28;
  // Reset values and limits (threshold 0.01 %Un, current 0.01 xIn, time ms)
  localparam logic [5:0] CTRL_RST = 6'h01;
  localparam logic [15:0] THR_RST = 16'h05dc;
  localparam logic [15:0] THR_MIN = 16'h000a;
  localparam logic [15:0] THR_MAX = 16'h1388;
  localparam logic [15:0] IMIN_RST = 16'h0064;
  localparam logic [15:0] MAXT_RST = 16'h3a98;
  localparam logic [15:0] MAXT_MIN = 16'h0014;
  localparam logic [15:0] MAXT_MAX = 16'hc350;
  localparam logic [4:0] HSEL_RST = 5'h02;
  localparam logic [4:0] HSEL_MIN = 5'h02;
  localparam logic [4:0] HSEL_MAX = 5'h1f;
  localparam logic [15:0] ANG_FULL = 16'h8ca0;
  localparam logic [31:0] PCT_SCALE = 32'h00002710;
  localparam logic [63:0] THD_SCALE = 64'h00000000000186a0;
  // Display modes
  localparam logic [1:0] DISP_PU = 2'h0;
  localparam logic [1:0] DISP_PRI = 2'h1;
  localparam logic [1:0] DISP_SEC = 2'h2;
  // Event bit positions
  localparam int EV_ON = 0;
  localparam int EV_OFF = 1;
  localparam int EV_EXP = 2;
  localparam int EV_BLK = 3;
  localparam int EV_W = 4;
  // AXI responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_HOLD = 2'h1,
    ST_EXP = 2'h3
  } vah_state_t;
  typedef struct packed {
    logic sync_mode;
    logic [1:0] disp;
    logic harm_abs;
    logic cur_en;
    logic en;
  } vah_ctrl_t;
endpackage

// ### rtl/vah_angle_hold.sv
// Voltage angle hold with AXI4-Lite registers and harmonic selection
`timescale 1ns/100ps
`default_nettype none
module vah_angle_hold #(
  parameter int NV = 6,
  parameter int PC_CLKS = vah_pkg::PC_CLKS
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Measurements from the front end
  input wire logic [NV-1:0][15:0] volt_mag_i,
  input wire logic [NV-1:0] volt_used_i,
  input wire logic [NV-1:0][15:0] volt_ang_i,
  input wire logic [2:0][15:0] cur_mag_i,
  input wire logic [15:0] u3_ang_i,
  input wire logic u3_used_i,
  input wire logic u4_used_i,
  input wire logic [29:0][15:0] harm_i,
  input wire logic [15:0] fund_i,
  input wire logic [15:0] vt_ratio_i,
  // Blocking pin
  input wire logic mem_block_i,
  // Outputs to protection stages
  output logic mem_on_o,
  output logic nondir_o,
  output logic irq_o,
  output logic [NV-1:0][15:0] volt_amp_o,
  output logic [NV-1:0][15:0] ref_ang_o,
  output logic [15:0] u3_ang_o,
  output logic u3_ang_valid_o,
  output logic [31:0] harm_sel_o,
  output logic [31:0] fund_o,
  output logic [31:0] peak_o,
  output logic [31:0] thd_amp_o,
  output logic [31:0] thd_pow_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Register state
  vah_pkg::vah_ctrl_t cfg, next_cfg;
  logic [15:0] thr, next_thr;
  logic [15:0] imin, next_imin;
  logic [15:0] maxt, next_maxt;
  logic [4:0] hsel, next_hsel;
  logic [vah_pkg::EV_W-1:0] isr, next_isr, imr, next_imr, ev;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic wr_go, rd_go;

  // Hold state
  vah_pkg::vah_state_t state, next_state;
  logic [15:0] tmr, next_tmr;
  logic [31:0] pc_cnt, next_pc_cnt;
  logic tick;
  logic blk_s1, blk_s2, blk_q, next_blk;
  logic [NV-1:0] below;
  logic [NV-1:0][15:0] ang_n, hold_ang, next_hold;
  logic [NV-1:0][15:0] next_amp, next_ang;
  logic vlow, chigh, arm, go;

  // Harmonic path
  logic [15:0] pk [0:30];
  logic [37:0] sq [0:30];
  logic [15:0] sel;
  logic [31:0] next_hsel_o, next_fund_o, next_peak_o;
  logic [31:0] next_thda, next_thdp;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] wmerge(input logic [31:0] old);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s_axi_wstrb[b]) begin
        r[8*b +: 8] = s_axi_wdata[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Keep a setting inside its allowed span
  function automatic logic [15:0] clamp(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Integer square root, bit by bit from the top
  function automatic logic [18:0] isqrt(input logic [37:0] x);
    logic [18:0] q;
    logic [18:0] c;
    q = '0;
    for (int i = 18; i >= 0; i--) begin
      c = q | (19'h00001 << i);
      if (38'({19'h00000, c} * {19'h00000, c}) <= x) begin
        q = c;
      end
    end
    return q;
  endfunction

  // Unmasked sticky events raise the level interrupt
  assign irq_o = |(isr & imr);
  assign tick = (pc_cnt == 32'(PC_CLKS - 1));
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign mem_on_o = (state == vah_pkg::ST_HOLD);
  assign nondir_o = (state == vah_pkg::ST_EXP);

  // Address and data taken together, one transfer per channel at a time
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid;
  assign rd_go = s_axi_arvalid && !rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  // Register file: writes, reads and the sticky event register
  always_comb begin
    logic [31:0] wv;
    wv = '0;
    next_cfg = cfg;
    next_thr = thr;
    next_imin = imin;
    next_maxt = maxt;
    next_hsel = hsel;
    next_imr = imr;
    next_isr = isr;
    next_bvalid = bvalid && !s_axi_bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !s_axi_rready;
    next_rresp = rresp;
    next_rdata = rdata;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp = vah_pkg::RESP_OK;
      case ({s_axi_awaddr[7:2], 2'h0})
        vah_pkg::OFF_CTRL: begin
          wv = wmerge({26'h0, cfg});
          next_cfg = vah_pkg::vah_ctrl_t'(wv[5:0]);
        end
        vah_pkg::OFF_THR: begin
          wv = wmerge({16'h0, thr});
          next_thr = clamp(wv[15:0], vah_pkg::THR_MIN, vah_pkg::THR_MAX);
        end
        vah_pkg::OFF_IMIN: begin
          wv = wmerge({16'h0, imin});
          next_imin = wv[15:0];
        end
        vah_pkg::OFF_MAXT: begin
          wv = wmerge({16'h0, maxt});
          next_maxt = clamp(wv[15:0], vah_pkg::MAXT_MIN, vah_pkg::MAXT_MAX);
        end
        vah_pkg::OFF_HSEL: begin
          wv = wmerge({27'h0, hsel});
          next_hsel = 5'(clamp({11'h0, wv[4:0]}, {11'h0, vah_pkg::HSEL_MIN},
              {11'h0, vah_pkg::HSEL_MAX}));
        end
        vah_pkg::OFF_IMR: begin
          wv = wmerge({28'h0, imr});
          next_imr = wv[vah_pkg::EV_W-1:0];
        end
        vah_pkg::OFF_STAT, vah_pkg::OFF_ISR, vah_pkg::OFF_HOUT,
        vah_pkg::OFF_THDA, vah_pkg::OFF_THDP: begin
          next_bresp = vah_pkg::RESP_OK;
        end
        default: begin
          next_bresp = vah_pkg::RESP_ERR;
        end
      endcase
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp = vah_pkg::RESP_OK;
      case ({s_axi_araddr[7:2], 2'h0})
        vah_pkg::OFF_CTRL: next_rdata = {26'h0, cfg};
        vah_pkg::OFF_THR: next_rdata = {16'h0, thr};
        vah_pkg::OFF_IMIN: next_rdata = {16'h0, imin};
        vah_pkg::OFF_MAXT: next_rdata = {16'h0, maxt};
        vah_pkg::OFF_HSEL: next_rdata = {27'h0, hsel};
        vah_pkg::OFF_STAT: next_rdata = {27'h0, nondir_o, blk_q, chigh, vlow, mem_on_o};
        vah_pkg::OFF_ISR: begin
          next_rdata = {28'h0, isr};
          next_isr = '0;
        end
        vah_pkg::OFF_IMR: next_rdata = {28'h0, imr};
        vah_pkg::OFF_HOUT: next_rdata = harm_sel_o;
        vah_pkg::OFF_THDA: next_rdata = thd_amp_o;
        vah_pkg::OFF_THDP: next_rdata = thd_pow_o;
        default: begin
          next_rdata = '0;
          next_rresp = vah_pkg::RESP_ERR;
        end
      endcase
    end
    // A new event wins over a clearing read in the same cycle
    next_isr = next_isr | ev;
  end

  // Register file flops
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg <= vah_pkg::vah_ctrl_t'(vah_pkg::CTRL_RST);
      thr <= vah_pkg::THR_RST;
      imin <= vah_pkg::IMIN_RST;
      maxt <= vah_pkg::MAXT_RST;
      hsel <= vah_pkg::HSEL_RST;
      isr <= '0;
      imr <= '0;
      bvalid <= 1'b0;
      bresp <= vah_pkg::RESP_OK;
      rvalid <= 1'b0;
      rresp <= vah_pkg::RESP_OK;
      rdata <= '0;
    end else begin
      cfg <= next_cfg;
      thr <= next_thr;
      imin <= next_imin;
      maxt <= next_maxt;
      hsel <= next_hsel;
      isr <= next_isr;
      imr <= next_imr;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // Per-channel compare and angle wrap into 0..359.99 degrees
  for (genvar i = 0; i < NV; i++) begin : g_ch
    assign below[i] = !volt_used_i[i] || (volt_mag_i[i] < thr);
    assign ang_n[i] = (volt_ang_i[i] >= vah_pkg::ANG_FULL) ?
        16'(volt_ang_i[i] - vah_pkg::ANG_FULL) : volt_ang_i[i];
  end

  // Activation terms; an unused set of voltages never counts as collapsed
  assign vlow = (&below) && (|volt_used_i);
  assign chigh = (cur_mag_i[0] > imin) || (cur_mag_i[1] > imin) ||
      (cur_mag_i[2] > imin);
  assign next_blk = tick ? blk_s2 : blk_q;
  assign arm = cfg.en && !next_blk;
  assign go = vlow && (!cfg.cur_en || chigh);

  // Hold sequencer, evaluated once per program cycle
  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_pc_cnt = tick ? 32'h0 : pc_cnt + 32'h1;
    next_hold = hold_ang;
    ev = '0;
    if (tick) begin
      case (state)
        vah_pkg::ST_IDLE: begin
          if (arm && go) begin
            next_state = vah_pkg::ST_HOLD;
            next_tmr = 16'h0;
          end else begin
            next_hold = ang_n;
          end
        end
        vah_pkg::ST_HOLD: begin
          if (!arm || !vlow) begin
            next_state = vah_pkg::ST_IDLE;
          end else if (tmr + 16'h1 >= maxt) begin
            next_state = vah_pkg::ST_EXP;
          end else begin
            next_tmr = tmr + 16'h1;
          end
        end
        vah_pkg::ST_EXP: begin
          // Rearm only after voltage returns or the block is disabled or blocked, so one fault gives one hold
          if (!arm || !vlow) begin
            next_state = vah_pkg::ST_IDLE;
          end
        end
        default: begin
          next_state = vah_pkg::ST_IDLE;
        end
      endcase
    end
    ev[vah_pkg::EV_ON] = (state != vah_pkg::ST_HOLD) && (next_state == vah_pkg::ST_HOLD);
    ev[vah_pkg::EV_OFF] = (state == vah_pkg::ST_HOLD) && (next_state != vah_pkg::ST_HOLD);
    ev[vah_pkg::EV_EXP] = (state != vah_pkg::ST_EXP) && (next_state == vah_pkg::ST_EXP);
    ev[vah_pkg::EV_BLK] = next_blk && !blk_q;
  end

  // Outputs to the stages follow the state of the next cycle
  always_comb begin
    for (int i = 0; i < NV; i++) begin
      next_amp[i] = (next_state == vah_pkg::ST_HOLD) ? thr : volt_mag_i[i];
      next_ang[i] = (next_state == vah_pkg::ST_HOLD) ? next_hold[i] : ang_n[i];
    end
  end

  // Hold state flops; the pin passes two flops before use
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= vah_pkg::ST_IDLE;
      tmr <= '0;
      pc_cnt <= '0;
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
      blk_q <= 1'b0;
      hold_ang <= '0;
      volt_amp_o <= '0;
      ref_ang_o <= '0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      pc_cnt <= next_pc_cnt;
      blk_s1 <= mem_block_i;
      blk_s2 <= blk_s1;
      blk_q <= next_blk;
      hold_ang <= next_hold;
      volt_amp_o <= next_amp;
      ref_ang_o <= next_ang;
    end
  end

  // Peak and sum of squares over orders 2..31
  assign pk[0] = 16'h0;
  assign sq[0] = 38'h0;
  for (genvar k = 0; k < 30; k++) begin : g_h
    assign pk[k+1] = (harm_i[k] > pk[k]) ? harm_i[k] : pk[k];
    assign sq[k+1] = sq[k] + 38'({16'h0, harm_i[k]} * {16'h0, harm_i[k]});
  end
  assign sel = harm_i[5'(hsel - vah_pkg::HSEL_MIN)];

  // Harmonic figures: percent of fundamental or absolute, scaled for display
  always_comb begin
    logic [31:0] f32;
    logic [63:0] fsq;
    f32 = {16'h0, fund_i};
    // Widen before multiplying so the square keeps all of its bits
    fsq = 64'(f32) * 64'(f32);
    next_fund_o = (cfg.disp == vah_pkg::DISP_PRI) ? f32 * {16'h0, vt_ratio_i} : f32;
    if (cfg.harm_abs) begin
      next_hsel_o = (cfg.disp == vah_pkg::DISP_PRI) ?
          {16'h0, sel} * {16'h0, vt_ratio_i} : {16'h0, sel};
      next_peak_o = (cfg.disp == vah_pkg::DISP_PRI) ?
          {16'h0, pk[30]} * {16'h0, vt_ratio_i} : {16'h0, pk[30]};
    end else if (fund_i != 16'h0) begin
      next_hsel_o = ({16'h0, sel} * vah_pkg::PCT_SCALE) / f32;
      next_peak_o = ({16'h0, pk[30]} * vah_pkg::PCT_SCALE) / f32;
    end else begin
      next_hsel_o = '0;
      next_peak_o = '0;
    end
    if (fund_i != 16'h0) begin
      next_thda = 32'((64'(isqrt(sq[30])) * vah_pkg::THD_SCALE) / 64'(f32));
      next_thdp = 32'((64'(sq[30]) * vah_pkg::THD_SCALE) / fsq);
    end else begin
      next_thda = '0;
      next_thdp = '0;
    end
  end

  // Harmonic and sync-angle outputs refresh once per program cycle
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      harm_sel_o <= '0;
      fund_o <= '0;
      peak_o <= '0;
      thd_amp_o <= '0;
      thd_pow_o <= '0;
      u3_ang_o <= '0;
      u3_ang_valid_o <= 1'b0;
    end else if (tick) begin
      harm_sel_o <= next_hsel_o;
      fund_o <= next_fund_o;
      peak_o <= next_peak_o;
      thd_amp_o <= next_thda;
      thd_pow_o <= next_thdp;
      u3_ang_o <= (u3_ang_i >= vah_pkg::ANG_FULL) ?
          16'(u3_ang_i - vah_pkg::ANG_FULL) : u3_ang_i;
      u3_ang_valid_o <= cfg.sync_mode && u3_used_i && u4_used_i;
    end
  end

  // Checks on the hold sequence and derived outputs
  // Block and disable act at the program tick, not at the register write
  AST_BLK_OFF:
    assert property (tick && (blk_s2 || !cfg.en) |=> !mem_on_o && !nondir_o)
    else $error("memory on while blocked or disabled");
  // Amplitude register lags a threshold write by one cycle
  AST_AMP_HELD:
    assert property (mem_on_o |-> volt_amp_o[0] == $past(thr))
    else $error("held amplitude differs from threshold");
  AST_ANG_STABLE:
    assert property (mem_on_o && $past(mem_on_o) |-> $stable(ref_ang_o))
    else $error("held angles moved during hold");
  AST_ACT_VLOW:
    assert property ($rose(mem_on_o) |-> $past(vlow) && $past(tick))
    else $error("activation without voltage collapse");
  AST_ACT_CUR:
    assert property ($rose(mem_on_o) && $past(cfg.cur_en) |-> $past(chigh))
    else $error("activation without phase current");
  AST_TMR_LIMIT:
    assert property (mem_on_o |-> tmr < maxt)
    else $error("hold timer beyond limit");
  AST_EXPIRE:
    assert property ($rose(nondir_o) |-> $past(mem_on_o) && ($past(tmr) + 16'h1 >= maxt))
    else $error("expiry without elapsed hold time");
  AST_EV_ON:
    assert property ($rose(mem_on_o) |-> isr[vah_pkg::EV_ON])
    else $error("activation event not recorded");
  AST_U3_VALID:
    assert property ($rose(u3_ang_valid_o) |-> $past(cfg.sync_mode && u3_used_i && u4_used_i))
    else $error("sync angle valid outside pair mode");
  AST_ANG_RANGE:
    assert property (ref_ang_o[0] < vah_pkg::ANG_FULL)
    else $error("angle outside full turn");
  AST_MAXT_SPAN:
    assert property (maxt >= vah_pkg::MAXT_MIN && maxt <= vah_pkg::MAXT_MAX)
    else $error("hold time setting out of span");
endmodule
`default_nettype wire

// ### bench/vah_fe_model.sv
// Measurement front end model feeding the voltage angle hold block
`timescale 1ns/100ps
`default_nettype none
module vah_fe_model (
  // Clock
  input wire logic sys_clk_i,
  // Scenario controls from the bench
  input wire logic [15:0] lvl_i,
  input wire logic [5:0] hi_i,
  input wire logic [15:0] cur_i,
  input wire logic [15:0] ang_i,
  // Measurements towards the block
  output logic [5:0][15:0] volt_mag_o = '0,
  output logic [5:0][15:0] volt_ang_o = '0,
  output logic [2:0][15:0] cur_mag_o = '0
);
  // New samples land just after the edge, one cycle behind the controls,
  // so the block never sees a magnitude and an angle from different scenes
  always @(posedge sys_clk_i) begin
    for (int i = 0; i < 6; i++) begin
      volt_mag_o[i] <= hi_i[i] ? 16'h2710 : lvl_i;
      volt_ang_o[i] <= ang_i + 16'(i * 100);
    end
    cur_mag_o <= {3{cur_i}};
  end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the voltage angle hold block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int PC = 8;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } vah_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [5:0] used = 6'h3f;
  logic [5:0] hi = 6'h00;
  logic [15:0] lvl = 16'h2710;
  logic [15:0] cur = 16'h0000;
  logic [15:0] ang = 16'h03e8;
  logic [29:0][15:0] harm = '0;
  logic [15:0] fund = 16'h03e8;
  logic [15:0] vt = 16'h0007;
  logic [15:0] u3a = 16'h8d04;
  logic u3u = 1'b0;
  logic u4u = 1'b0;
  logic blk = 1'b0;
  logic mem_on, nondir, irq, u3v;
  logic [5:0][15:0] amp, rang, vmag, vang;
  logic [2:0][15:0] cmag;
  logic [15:0] u3o;
  logic [31:0] hsel, fundo, peak, thda, thdp;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  time t0;
  // Register table: reset values, clamping of settings, unmapped offset
  vah_row_t rows [18] = '{
    '{1'b0, 8'h00, 32'h0, 32'h01, 2'h0}, '{1'b0, 8'h04, 32'h0, 32'h5dc, 2'h0},
    '{1'b0, 8'h08, 32'h0, 32'h64, 2'h0}, '{1'b0, 8'h0c, 32'h0, 32'h3a98, 2'h0},
    '{1'b0, 8'h10, 32'h0, 32'h02, 2'h0}, '{1'b0, 8'h18, 32'h0, 32'h0, 2'h0},
    '{1'b0, 8'h1c, 32'h0, 32'h0, 2'h0}, '{1'b1, 8'h04, 32'h5, 32'ha, 2'h0},
    '{1'b1, 8'h04, 32'h1389, 32'h1388, 2'h0}, '{1'b1, 8'h04, 32'h5dc, 32'h5dc, 2'h0},
    '{1'b1, 8'h0c, 32'h13, 32'h14, 2'h0}, '{1'b1, 8'h0c, 32'hc351, 32'hc350, 2'h0},
    '{1'b1, 8'h10, 32'h1, 32'h2, 2'h0}, '{1'b1, 8'h10, 32'h20, 32'h2, 2'h0},
    '{1'b1, 8'h10, 32'h5, 32'h5, 2'h0}, '{1'b1, 8'h30, 32'h7, 32'h0, 2'h2},
    '{1'b1, 8'h0c, 32'h14, 32'h14, 2'h0}, '{1'b1, 8'h14, 32'h1f, 32'h0, 2'h0}};
  // Harmonic modes: control word and expected selected harmonic
  logic [31:0] hm [4][2] = '{'{32'h05, 32'h12c}, '{32'h0d, 32'h834},
    '{32'h15, 32'h12c}, '{32'h01, 32'hbb8}};

  always #5 sys_clk = ~sys_clk;

  vah_fe_model vah_fe_model_inst (.sys_clk_i(sys_clk), .lvl_i(lvl), .hi_i(hi),
    .cur_i(cur), .ang_i(ang), .volt_mag_o(vmag), .volt_ang_o(vang), .cur_mag_o(cmag));

  vah_angle_hold #(.NV(6), .PC_CLKS(PC)) vah_angle_hold_inst (.sys_clk_i(sys_clk),
    .reset_n_i(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .volt_mag_i(vmag), .volt_used_i(used), .volt_ang_i(vang), .cur_mag_i(cmag),
    .u3_ang_i(u3a), .u3_used_i(u3u), .u4_used_i(u4u), .harm_i(harm), .fund_i(fund),
    .vt_ratio_i(vt), .mem_block_i(blk), .mem_on_o(mem_on), .nondir_o(nondir),
    .irq_o(irq), .volt_amp_o(amp), .ref_ang_o(rang), .u3_ang_o(u3o),
    .u3_ang_valid_o(u3v), .harm_sel_o(hsel), .fund_o(fundo), .peak_o(peak),
    .thd_amp_o(thda), .thd_pow_o(thdp));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Write: address and data held until the edge that takes them; values read
  // just after an edge are still those that the edge sampled
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge sys_clk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  // Read one register, data taken at the edge that sees rvalid
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Let whole program cycles pass
  task automatic tk(input int n);
    repeat (n * PC) @(posedge sys_clk);
  endtask

  // Wait at most n cycles for the hold output to reach v
  task automatic see(input logic v, input int n);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (mem_on !== v && k < n);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("unexpected at %0t: run too long", $time);
      results();
    end
  end

  initial begin
    harm[3] = 16'h012c;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(mem_on, 1'b0);
    chk(nondir, 1'b0);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axw(rows[i].a, rows[i].d, r);
        chk(r, rows[i].r);
      end
      axr(rows[i].a, d, r);
      chk(d, rows[i].e);
      chk(r, rows[i].r);
    end
    $display("register table done");
    // Collapse with a used channel still healthy, then with it out of use
    axw(8'h0c, 32'h1f4, r);
    tk(2);
    chk(amp[1], 16'h2710);
    hi <= 6'h01;
    lvl <= 16'h0064;
    tk(3);
    chk(mem_on, 1'b0);
    used <= 6'h3e;
    ang <= 16'h07d0;
    see(1'b1, 2 * PC);
    t0 = $time;
    chk(mem_on, 1'b1);
    chk(amp[1], 16'h05dc);
    chk(rang[1], 16'h044c);
    chk(irq, 1'b0);
    axw(8'h1c, 32'hf, r);
    chk(irq, 1'b1);
    axr(8'h18, d, r);
    chk(d, 32'h1);
    chk(irq, 1'b0);
    $display("activation done");
    // Hold time runs out while voltage stays low; no rearm before recovery
    see(1'b0, 520 * PC);
    chk(32'(($time - t0) / 10), 32'(500 * PC));
    chk(nondir, 1'b1);
    axr(8'h18, d, r);
    chk(d, 32'h6);
    tk(3);
    chk(mem_on, 1'b0);
    lvl <= 16'h2710;
    hi <= 6'h00;
    used <= 6'h3f;
    tk(2);
    chk(nondir, 1'b0);
    $display("expiry done");
    // Current condition: a current equal to the floor is not enough
    axw(8'h00, 32'h3, r);
    lvl <= 16'h0064;
    cur <= 16'h0064;
    tk(3);
    chk(mem_on, 1'b0);
    cur <= 16'h0065;
    see(1'b1, 2 * PC);
    chk(mem_on, 1'b1);
    $display("current condition done");
    // Blocking drops the hold, release rearms it, disable drops it again
    blk <= 1'b1;
    see(1'b0, PC + 4);
    chk(mem_on, 1'b0);
    axr(8'h18, d, r);
    chk(d & 32'h8, 32'h8);
    tk(3);
    chk(mem_on, 1'b0);
    blk <= 1'b0;
    see(1'b1, PC + 4);
    chk(mem_on, 1'b1);
    axw(8'h00, 32'h0, r);
    see(1'b0, PC + 2);
    chk(mem_on, 1'b0);
    lvl <= 16'h2710;
    cur <= 16'h0000;
    $display("blocking done");
    // Harmonic scaling modes, then figures in absolute per-unit
    foreach (hm[i]) begin
      axw(8'h00, hm[i][0], r);
      tk(2);
      chk(hsel, hm[i][1]);
    end
    axw(8'h00, 32'h05, r);
    tk(2);
    chk(fundo, 32'h3e8);
    chk(peak, 32'h12c);
    chk(thda, 32'h7530);
    chk(thdp, 32'h2328);
    $display("harmonics done");
    // Angle wrap and sync input validity over every combination
    ang <= 16'h8e94;
    tk(2);
    chk(rang[0], 16'h01f4);
    for (int k = 0; k < 8; k++) begin
      axw(8'h00, {26'h0, k[2], 5'h01}, r);
      u3u <= k[1];
      u4u <= k[0];
      tk(2);
      chk(u3v, k == 7);
    end
    chk(u3o, 16'h0064);
    $display("angles done");
    // Reset in mid-run clears the outputs and restores the settings
    rst_n <= 1'b0;
    tk(1);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(u3v, 1'b0);
    axr(8'h0c, d, r);
    chk(d, 32'h3a98);
    $display("reset done");
    results();
  end
endmodule
`default_nettype wire
